// file: logic/dol_pkg.sv
// constants for the debug os lock and vm id breakpoint match block
`default_nettype none
package dol_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_BKPT_VMID0 = 12'h000;
  localparam logic [11:0] OFF_BKPT_VMID1 = 12'h004;
  localparam logic [11:0] OFF_LOCK_KEY = 12'h010;
  localparam logic [11:0] OFF_LOCK_STATE = 12'h014;
  localparam logic [11:0] OFF_DEBUG_ID = 12'h018;
  localparam logic [11:0] OFF_DEBUG_CTRL = 12'h01C;
  localparam logic [31:0] LOCK_KEY = 32'hC5ACCE55;
  localparam int BKPT_PAIRS = 2;
  localparam int VIRTUAL_MACHINE_IDENTIFIER_W = 8;
  localparam int LSR_LOCK_BIT = 1;
  localparam int LSR_NTT_BIT = 2;
  localparam int LSR_LM0_BIT = 0;
  localparam int LSR_LM1_BIT = 3;
  localparam logic [1:0] LOCK_MODEL = 2'h2;
  localparam int DIDR_CTX_LSB = 20;
  localparam logic [3:0] DIDR_CTX_CMP = 4'h1;
  localparam logic LOCK_RESET = 1'b1;
  localparam int CTRL_BKPT_EN_LSB = 0;
  localparam int CTRL_ACCESS_GATE_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : dol_pkg
`default_nettype wire

// file: logic/dol_virtual_machine_identifier_cmp.sv
// one breakpoint pair compare stage for vm id matching
`timescale 1ns/10ps
`default_nettype none
module dol_virtual_machine_identifier_cmp #(
  parameter int VIRTUAL_MACHINE_IDENTIFIER_W = 8
) (
  // clocking
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // compare inputs
  input wire logic enable,
  input wire logic addr_match,
  input wire logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] stored_virtual_machine_identifier,
  input wire logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] current_virtual_machine_identifier,
  input wire logic commit,
  input wire logic suppress,
  // result
  output logic event_out
);
  wire hit;
  // event only at commit, never while the lock suppresses it
  assign hit = enable && addr_match && commit && !suppress
    && (stored_virtual_machine_identifier == current_virtual_machine_identifier); // [R03] [R04] [R07]

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      event_out <= 1'b0;
    else if (clk_en)
      event_out <= hit;
  end
endmodule // dol_virtual_machine_identifier_cmp
`default_nettype wire

// file: logic/dol_top.sv
// debug os lock and per-breakpoint vm id match registers, axi4-lite slave
// Contract
// R01: each vm id value register n joins control and value register n to form breakpoint n.
// R02: two breakpoint pairs support vm id matching, reported in the context comparator field.
// R03: bits 7:0 hold the vm id compared to the current one, upper bits read zero.
// R04: a breakpoint event fires only when a matching instruction commits.
// R05: writing the key word sets the os lock.
// R06: writing any other value clears the os lock.
// R07: while locked, software debug events are suppressed.
// R08: status bit 1 shows the lock state.
// R09: reset sets the lock.
// R10: while locked, access to the debug registers is restricted.
// R11: lock model field in status bits 3 and 0 reads binary 10.
// R12: status bit 2 reads zero, key must be a full 32-bit write.
// R13: lock model field would read zero without the save/restore scheme.
// R14: the lock key register reads zero.
`timescale 1ns/10ps
`default_nettype none
module dol_top #(
  parameter int PAIRS = dol_pkg::BKPT_PAIRS,
  parameter int VIRTUAL_MACHINE_IDENTIFIER_W = dol_pkg::VIRTUAL_MACHINE_IDENTIFIER_W,
  parameter bit LOCK_MODEL_PRESENT = 1'b1
) (
  // clocking
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // axi4-lite write address
  input wire logic [dol_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [dol_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic [PAIRS-1:0] bkpt_addr_match,
  input wire logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] current_virtual_machine_identifier,
  input wire logic instr_commit,
  // results
  output logic [PAIRS-1:0] bkpt_event,
  output logic os_lock
);
  logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] virtual_machine_identifier_val [PAIRS];
  logic [PAIRS-1:0] bkpt_en;
  logic access_gate;
  logic aw_held;
  logic w_held;
  logic [dol_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // address decode helper, used by both channels
  function automatic logic [3:0] dec(input logic [dol_pkg::ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    case ({a[dol_pkg::ADDR_W-1:2], 2'b00})
      dol_pkg::OFF_BKPT_VMID0: r = 4'h1;
      dol_pkg::OFF_BKPT_VMID1: r = 4'h2;
      dol_pkg::OFF_LOCK_KEY: r = 4'h3;
      dol_pkg::OFF_LOCK_STATE: r = 4'h4;
      dol_pkg::OFF_DEBUG_ID: r = 4'h5;
      dol_pkg::OFF_DEBUG_CTRL: r = 4'h6;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // write channel: both halves captured in any order, then one response
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] wsel = dec(aw_addr);
  wire full_word = (w_strb == 4'hF);
  wire bkpt_sel = (wsel == 4'h1) || (wsel == 4'h2);
  wire bkpt_idx = (wsel == 4'h2);
  // breakpoint registers refused while locked and the gate is on
  wire bkpt_blocked = os_lock && access_gate; // [R10]
  wire wr_bkpt = wr_go && bkpt_sel && !bkpt_blocked;
  // partial writes to the key register are refused, no lock change
  wire wr_key = wr_go && (wsel == 4'h3) && full_word; // [R12]
  wire wr_ctrl = wr_go && (wsel == 4'h6);
  wire wr_err = wr_go && (wsel == 4'h0);
  wire wr_slv = wr_go && ((bkpt_sel && bkpt_blocked) || ((wsel == 4'h3) && !full_word)
    || (wsel == 4'h4) || (wsel == 4'h5));
  wire next_lock = (w_data == dol_pkg::LOCK_KEY); // [R05] [R06]

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dol_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? dol_pkg::RESP_DECERR
          : (wr_slv ? dol_pkg::RESP_SLVERR : dol_pkg::RESP_OKAY);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // lock state, set at reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      os_lock <= dol_pkg::LOCK_RESET; // [R09]
    else if (clk_en && wr_key)
      os_lock <= next_lock; // [R05] [R06]
  end

  // breakpoint vm id values and control
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PAIRS; i++)
        virtual_machine_identifier_val[i] <= '0;
      bkpt_en <= '0;
      access_gate <= 1'b1;
    end
    else if (clk_en)
    begin
      if (wr_bkpt && w_strb[0])
        virtual_machine_identifier_val[bkpt_idx] <= w_data[VIRTUAL_MACHINE_IDENTIFIER_W-1:0]; // [R03]
      if (wr_ctrl && w_strb[0])
      begin
        bkpt_en <= w_data[dol_pkg::CTRL_BKPT_EN_LSB +: PAIRS];
        access_gate <= w_data[dol_pkg::CTRL_ACCESS_GATE_BIT];
      end
    end
  end

  // read side
  wire [3:0] rsel = dec(s_axi_araddr);
  wire [1:0] lock_model = LOCK_MODEL_PRESENT ? dol_pkg::LOCK_MODEL : 2'h0; // [R13]
  logic [31:0] lsr_word;
  logic [31:0] rd_word;
  always_comb
  begin
    lsr_word = 32'h0;
    lsr_word[dol_pkg::LSR_LM1_BIT] = lock_model[1]; // [R11]
    lsr_word[dol_pkg::LSR_LM0_BIT] = lock_model[0]; // [R11]
    lsr_word[dol_pkg::LSR_NTT_BIT] = 1'b0; // [R12]
    lsr_word[dol_pkg::LSR_LOCK_BIT] = os_lock; // [R08]
  end
  always_comb
  begin
    rd_word = 32'h0;
    case (rsel)
      4'h1: rd_word = {{(32-VIRTUAL_MACHINE_IDENTIFIER_W){1'b0}}, virtual_machine_identifier_val[0]}; // [R01] [R03]
      4'h2: rd_word = {{(32-VIRTUAL_MACHINE_IDENTIFIER_W){1'b0}}, virtual_machine_identifier_val[1]}; // [R01] [R03]
      4'h3: rd_word = 32'h0; // [R14]
      4'h4: rd_word = lsr_word;
      4'h5: rd_word[dol_pkg::DIDR_CTX_LSB +: 4] = dol_pkg::DIDR_CTX_CMP; // [R02]
      4'h6: rd_word = {27'h0, access_gate, 2'h0, bkpt_en};
      default: rd_word = 32'h0;
    endcase
  end
  wire rd_blocked = ((rsel == 4'h1) || (rsel == 4'h2)) && bkpt_blocked; // [R10]

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dol_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_blocked ? 32'h0 : rd_word;
        s_axi_rresp <= (rsel == 4'h0) ? dol_pkg::RESP_DECERR
          : (rd_blocked ? dol_pkg::RESP_SLVERR : dol_pkg::RESP_OKAY);
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // one compare stage per pair
  for (genvar g = 0; g < PAIRS; g++)
  begin : g_pair
    dol_virtual_machine_identifier_cmp #(.VIRTUAL_MACHINE_IDENTIFIER_W(VIRTUAL_MACHINE_IDENTIFIER_W)) u_cmp (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .enable(bkpt_en[g]),
      .addr_match(bkpt_addr_match[g]),
      .stored_virtual_machine_identifier(virtual_machine_identifier_val[g]),
      .current_virtual_machine_identifier(current_virtual_machine_identifier),
      .commit(instr_commit),
      .suppress(os_lock), // [R07]
      .event_out(bkpt_event[g])
    );
  end

  // checks
  property p_key_sets;
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_key && w_data == dol_pkg::LOCK_KEY) |=> os_lock;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("key write did not lock"); // [R05]

  property p_other_clears;
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_key && w_data != dol_pkg::LOCK_KEY) |=> !os_lock;
  endproperty
  a_other_clears: assert property (p_other_clears) else $error("lock not cleared"); // [R06]

  property p_suppress;
    @(posedge sys_clk) disable iff (sys_rst)
    ($past(os_lock) && $past(clk_en)) |-> (bkpt_event == '0);
  endproperty
  a_suppress: assert property (p_suppress) else $error("event while locked"); // [R07]

  property p_commit;
    @(posedge sys_clk) disable iff (sys_rst)
    (bkpt_event != '0) |-> $past(instr_commit);
  endproperty
  a_commit: assert property (p_commit) else $error("event without commit"); // [R04]

  property p_status;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && clk_en && rsel == 4'h4) |=>
      (s_axi_rdata[3:0] == {lock_model[1], 1'b0, $past(os_lock), lock_model[0]});
  endproperty
  a_status: assert property (p_status) else $error("lock status word wrong"); // [R08] [R11] [R12]

  property p_reset_lock;
    @(posedge sys_clk) $fell(sys_rst) |-> os_lock;
  endproperty
  a_reset_lock: assert property (p_reset_lock) else $error("not locked after reset"); // [R09]

  property p_key_reads_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && clk_en && rsel == 4'h3) |=> (s_axi_rdata == 32'h0);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read not zero"); // [R14]

  property p_blocked;
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_go && bkpt_sel && bkpt_blocked) |=> $stable(virtual_machine_identifier_val[0]) && $stable(virtual_machine_identifier_val[1]);
  endproperty
  a_blocked: assert property (p_blocked) else $error("locked write changed value"); // [R10]

  property p_partial_key;
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && wr_go && wsel == 4'h3 && !full_word) |=> $stable(os_lock);
  endproperty
  a_partial_key: assert property (p_partial_key) else $error("partial key write acted"); // [R12]

  c_lock: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(os_lock));
  c_unlock: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(os_lock));
  c_event: cover property (@(posedge sys_clk) disable iff (sys_rst) bkpt_event[1]);
endmodule // dol_top
`default_nettype wire

// file: test/dol_top_test.sv
// self-checking bench for the debug os lock and vm id match block
`timescale 1ns/10ps
`default_nettype none
module dol_top_test;
  logic sys_clk, sys_rst, clk_en;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bkpt_addr_match, bkpt_event;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] current_virtual_machine_identifier;
  logic instr_commit, os_lock;
  logic [31:0] rd;
  logic [1:0] rs;
  int err_count = 0;
  int tests_run = 0;

  dol_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bkpt_addr_match(bkpt_addr_match), .current_virtual_machine_identifier(current_virtual_machine_identifier),
    .instr_commit(instr_commit), .bkpt_event(bkpt_event), .os_lock(os_lock));

  // copy without the save/restore scheme, in lockstep on the same stimulus
  logic [31:0] rdata_nolm;
  dol_top #(.LOCK_MODEL_PRESENT(1'b0)) i_dut_nolm (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(), .s_axi_rdata(rdata_nolm), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(s_axi_rready), .bkpt_addr_match(bkpt_addr_match),
    .current_virtual_machine_identifier(current_virtual_machine_identifier), .instr_commit(instr_commit), .bkpt_event(), .os_lock());

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // handshakes are judged on the settled level just before the edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    bit ta, tw, tb;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 50 && !tb; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready & clk_en;
      tw = s_axi_wvalid & s_axi_wready & clk_en;
      tb = s_axi_bvalid & s_axi_bready & clk_en;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb)
    begin
      err_count++;
      final_report();
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ta, tr;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 50 && !tr; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready & clk_en;
      tr = s_axi_rvalid & s_axi_rready & clk_en;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr)
    begin
      err_count++;
      final_report();
    end
  endtask

  // one commit cycle, event expected one edge later for one cycle only
  task automatic fire(input logic [1:0] m, input logic [7:0] v, input logic c,
                      input logic [1:0] exp);
    @(posedge sys_clk);
    bkpt_addr_match <= m;
    current_virtual_machine_identifier <= v;
    instr_commit <= c;
    @(posedge sys_clk);
    instr_commit <= 1'b0;
    bkpt_addr_match <= 2'h0;
    #1 check(bkpt_event, exp);
    @(posedge sys_clk);
    #1 check(bkpt_event, 32'h0);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    bkpt_addr_match = 2'h0;
    current_virtual_machine_identifier = 8'h00;
    instr_commit = 1'b0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check(os_lock, 32'h1);
    axi_read(12'h014, rd, rs);
    check(rd, 32'h0000000A);
    check(rdata_nolm, 32'h00000002);
    axi_read(12'h018, rd, rs);
    check((rd >> 20) & 32'hF, 32'h1);
    axi_read(12'h010, rd, rs);
    check(rd, 32'h0);
    axi_read(12'h100, rd, rs);
    check(rs, 32'h3);
    $display("test reset_values done");
    // locked: vm id access refused, narrow key write refused
    axi_write(12'h000, 32'h00000077, 4'hF, rs);
    check(rs, 32'h2);
    axi_write(12'h010, 32'h00001234, 4'h3, rs);
    check(rs, 32'h2);
    check(os_lock, 32'h1);
    $display("test locked_access done");
    axi_write(12'h010, 32'h00000000, 4'hF, rs);
    check(rs, 32'h0);
    check(os_lock, 32'h0);
    axi_read(12'h014, rd, rs);
    check(rd, 32'h00000008);
    check(rdata_nolm, 32'h00000000);
    axi_read(12'h000, rd, rs);
    check(rd, 32'h0);
    axi_write(12'h000, 32'hFFFFFF5A, 4'hF, rs);
    axi_write(12'h004, 32'h000000A5, 4'hF, rs);
    axi_read(12'h000, rd, rs);
    check(rd, 32'h0000005A);
    axi_read(12'h004, rd, rs);
    check(rd, 32'h000000A5);
    $display("test unlock_and_virtual_machine_identifier done");
    axi_write(12'h01C, 32'h00000013, 4'hF, rs);
    axi_read(12'h01C, rd, rs);
    check(rd, 32'h00000013);
    // frozen enable: a matching commit must not raise an event
    @(posedge sys_clk);
    clk_en <= 1'b0;
    fire(2'b01, 8'h5A, 1'b1, 2'b00);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    fire(2'b01, 8'h5A, 1'b1, 2'b01);
    fire(2'b11, 8'hA5, 1'b1, 2'b10);
    fire(2'b01, 8'h5B, 1'b1, 2'b00);
    fire(2'b11, 8'h5A, 1'b0, 2'b00);
    $display("test events done");
    axi_write(12'h010, 32'hC5ACCE55, 4'hF, rs);
    check(os_lock, 32'h1);
    fire(2'b01, 8'h5A, 1'b1, 2'b00);
    axi_read(12'h000, rd, rs);
    check({rs, rd[29:0]}, 32'h80000000);
    axi_read(12'h014, rd, rs);
    check(rd, 32'h0000000A);
    $display("test relock done");
    final_report();
  end
endmodule // dol_top_test
`default_nettype wire
